// ===== rtl/rsa_pkg.sv
// rsa_pkg: constants, opcodes and operand selectors for the rotate/subtract alu
// assumes one core clock; the instruction decoder drives one operation per cycle
package rsa_pkg;
    typedef enum logic [2:0] {
        OP_ACC_ROTATE_LEFT_CIRCULAR,
        OP_ACC_ROTATE_RIGHT_VIA_CFLAG,
        OP_BYTE_ROTATE_RIGHT_VIA_CFLAG,
        OP_WORD_ROTATE_RIGHT_CIRCULAR,
        OP_BYTE_SUBTRACT_BORROW,
        OP_WORD_SUBTRACT_BORROW
    } rsa_op_t;

    typedef enum logic [1:0] {
        SRC_EXTERNAL,
        SRC_PAIR,
        SRC_INDEX
    } rsa_src_t;

    // flag bit positions in the flag register
    localparam int FLG_S  = 7;
    localparam int FLG_Z  = 6;
    localparam int FLG_H  = 4;
    localparam int FLG_PV = 2;
    localparam int FLG_N  = 1;
    localparam int FLG_C  = 0;

    // pair field codes
    localparam logic [1:0] PAIR_FIRST  = 2'h0;
    localparam logic [1:0] PAIR_SECOND = 2'h1;
    localparam logic [1:0] PAIR_ACC    = 2'h3;

    // word register file slots
    localparam logic [2:0] SLOT_FIRST_PAIR  = 3'h0;
    localparam logic [2:0] SLOT_SECOND_PAIR = 3'h1;
    localparam logic [2:0] SLOT_ACC_PAIR    = 3'h2;
    localparam logic [2:0] SLOT_FIRST_INDEX = 3'h3;
    localparam int         NUM_SLOTS        = 5;

    // register port byte offsets
    localparam logic [7:0] OFS_ACC    = 8'h00;
    localparam logic [7:0] OFS_FLAGS  = 8'h04;
    localparam logic [7:0] OFS_SLOT0  = 8'h08;
    localparam logic [7:0] OFS_RESULT = 8'h1C;
    localparam logic [7:0] OFS_COUNT  = 8'h20;

    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
endpackage

// ===== rtl/rsa_alu.sv
// rsa_alu: rotate and subtract-with-borrow datapath with its own register state
// assumes decoder strobes op_valid one cycle per operation; register port is
// a plain strobe port with read data one cycle after the read strobe
`timescale 1ns/1ps
module rsa_alu
    import rsa_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [15:0]       reg_rdata_q,
    // decoder operation port
    input  wire logic              op_valid,
    input  wire rsa_op_t           op_code,
    input  wire rsa_src_t          src_mode,
    input  wire logic [1:0]        pair_sel,
    input  wire logic              index_sel,
    input  wire logic              byte_sel,
    input  wire logic [15:0]       operand_in,
    // results
    output logic      [15:0]       result_q,
    output logic                   result_valid_q,
    output logic      [7:0]        flags_q
);
    if (ADDR_W < 6) begin : g_chk
        $error("rsa_alu: ADDR_W must be at least 6");
    end

    logic [7:0]  a_q;
    logic [15:0] regs_q [NUM_SLOTS];
    logic [15:0] count_q;

    function automatic logic [2:0] pair_slot(input logic [1:0] sel);
        // rr=10 has no pair; it falls back to the word accumulator pair
        case (sel)
            PAIR_FIRST:  pair_slot = SLOT_FIRST_PAIR;
            PAIR_SECOND: pair_slot = SLOT_SECOND_PAIR;
            default:     pair_slot = SLOT_ACC_PAIR;
        endcase
    endfunction

    // operand selection
    wire  [2:0]  idx_slot   = SLOT_FIRST_INDEX + {2'h0, index_sel};
    wire  [15:0] index_word = regs_q[idx_slot];
    wire  [2:0]  pr_slot    = pair_slot(pair_sel);
    wire  [15:0] pair_word  = regs_q[pr_slot];
    wire  [15:0] src_word   = (src_mode == SRC_PAIR)  ? pair_word :
                              (src_mode == SRC_INDEX) ? index_word : operand_in;
    wire  [7:0]  src_byte   = (src_mode != SRC_INDEX) ? operand_in[7:0] :
                              (byte_sel ? index_word[7:0] : index_word[15:8]);
    wire         wb_slot_ok = (src_mode == SRC_PAIR) || (src_mode == SRC_INDEX);
    wire  [2:0]  wb_slot    = (src_mode == SRC_INDEX) ? idx_slot : pr_slot;
    wire         c_in       = flags_q[FLG_C];
    wire  [15:0] acc_word   = regs_q[SLOT_ACC_PAIR];

    wire  [8:0]  bdiff = {1'b0, a_q} - {1'b0, src_byte} - {8'h00, c_in};
    // borrow out of the low nibble
    wire  [4:0]  bhalf = {1'b0, a_q[3:0]} - {1'b0, src_byte[3:0]} - {4'h0, c_in};
    wire  [16:0] wdiff = {1'b0, acc_word} - {1'b0, src_word} - {16'h0000, c_in};
    // borrow out of the low twelve bits
    wire  [12:0] whalf = {1'b0, acc_word[11:0]} - {1'b0, src_word[11:0]}
                         - {12'h000, c_in};

    logic [7:0]  a_d;
    logic [7:0]  f_d;
    logic [15:0] res_d;
    logic        wb_en;
    logic [15:0] wb_val;

    always_comb begin
        a_d    = a_q;
        f_d    = flags_q;
        res_d  = result_q;
        wb_en  = 1'b0;
        wb_val = RST_WORD;
        case (op_code)
            OP_ACC_ROTATE_LEFT_CIRCULAR: begin
                // bit 7 into bit 0 and carry
                a_d        = {a_q[6:0], a_q[7]};
                f_d[FLG_C] = a_q[7];
                f_d[FLG_H] = 1'b0;
                f_d[FLG_N] = 1'b0;
                res_d      = {8'h00, a_d};
            end
            OP_ACC_ROTATE_RIGHT_VIA_CFLAG: begin
                // carry into bit 7, bit 0 into carry
                a_d        = {c_in, a_q[7:1]};
                f_d[FLG_C] = a_q[0];
                f_d[FLG_H] = 1'b0;
                f_d[FLG_N] = 1'b0;
                res_d      = {8'h00, a_d};
            end
            OP_BYTE_ROTATE_RIGHT_VIA_CFLAG: begin
                res_d       = {8'h00, c_in, src_byte[7:1]};
                f_d[FLG_C]  = src_byte[0];
                f_d[FLG_S]  = res_d[7];
                f_d[FLG_Z]  = (res_d[7:0] == RST_BYTE);
                f_d[FLG_PV] = ~^res_d[7:0];
                f_d[FLG_H]  = 1'b0;
                f_d[FLG_N]  = 1'b0;
            end
            OP_WORD_ROTATE_RIGHT_CIRCULAR: begin
                // bit 0 into bit 15 and carry
                res_d       = {src_word[0], src_word[15:1]};
                wb_en       = wb_slot_ok;
                wb_val      = res_d;
                f_d[FLG_C]  = src_word[0];
                f_d[FLG_S]  = res_d[15];
                f_d[FLG_Z]  = (res_d == RST_WORD);
                f_d[FLG_PV] = ~^res_d;
                f_d[FLG_H]  = 1'b0;
                f_d[FLG_N]  = 1'b0;
            end
            OP_BYTE_SUBTRACT_BORROW: begin
                a_d         = bdiff[7:0];
                res_d       = {8'h00, bdiff[7:0]};
                f_d[FLG_H]  = bhalf[4];
                f_d[FLG_PV] = (a_q[7] != src_byte[7]) && (bdiff[7] == src_byte[7]);
                f_d[FLG_S]  = bdiff[7];
                f_d[FLG_Z]  = (bdiff[7:0] == RST_BYTE);
                f_d[FLG_N]  = 1'b1;
                f_d[FLG_C]  = bdiff[8];
            end
            OP_WORD_SUBTRACT_BORROW: begin
                res_d       = wdiff[15:0];
                f_d[FLG_H]  = whalf[12];
                f_d[FLG_PV] = (acc_word[15] != src_word[15])
                              && (wdiff[15] == src_word[15]);
                f_d[FLG_S]  = wdiff[15];
                f_d[FLG_Z]  = (wdiff[15:0] == RST_WORD);
                f_d[FLG_N]  = 1'b1;
                f_d[FLG_C]  = wdiff[16];
            end
            default: begin
                res_d = result_q;
            end
        endcase
    end

    // register port decode
    wire [ADDR_W-1:0] off_acc   = ADDR_W'(OFS_ACC);
    wire [ADDR_W-1:0] off_flags = ADDR_W'(OFS_FLAGS);
    wire [ADDR_W-1:0] off_res   = ADDR_W'(OFS_RESULT);
    wire [ADDR_W-1:0] off_cnt   = ADDR_W'(OFS_COUNT);
    wire [ADDR_W-1:0] slot_rel  = reg_addr - ADDR_W'(OFS_SLOT0);
    wire              slot_hit  = (reg_addr >= ADDR_W'(OFS_SLOT0))
                                  && (reg_addr < off_res) && (reg_addr[1:0] == 2'h0);
    wire [2:0]        slot_num  = slot_rel[4:2];
    wire [15:0]       rd_mux    = (reg_addr == off_acc)   ? {8'h00, a_q} :
                                  (reg_addr == off_flags) ? {8'h00, flags_q} :
                                  slot_hit                ? regs_q[slot_num] :
                                  (reg_addr == off_res)   ? result_q :
                                  (reg_addr == off_cnt)   ? count_q : RST_WORD;
    wire              op_word_sub = op_valid && (op_code == OP_WORD_SUBTRACT_BORROW);

    // an operation in the same cycle as a port write wins over that write
    // result and flags commit together
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            a_q            <= RST_BYTE;
            flags_q        <= RST_BYTE;
            result_q       <= RST_WORD;
            result_valid_q <= 1'b0;
            count_q        <= RST_WORD;
        end else begin
            result_valid_q <= op_valid;
            if (op_valid) begin
                a_q      <= a_d;
                flags_q  <= f_d;
                result_q <= res_d;
                count_q  <= count_q + 16'h0001;
            end else if (reg_wr && reg_addr == off_acc) begin
                a_q <= reg_wdata[7:0];
            end else if (reg_wr && reg_addr == off_flags) begin
                flags_q <= reg_wdata[7:0];
            end
        end
    end

    // only the destination slot is written
    for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
        wire op_hit = (op_word_sub && (i == int'(SLOT_ACC_PAIR)))
                      || (op_valid && wb_en && (i == int'(wb_slot)));
        wire [15:0] op_val = op_word_sub ? wdiff[15:0] : wb_val;
        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                regs_q[i] <= RST_WORD;
            end else if (op_hit) begin
                regs_q[i] <= op_val;
            end else if (reg_wr && slot_hit && (slot_num == 3'(i))) begin
                regs_q[i] <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_rdata_q <= RST_WORD;
        end else begin
            reg_rdata_q <= reg_rd ? rd_mux : RST_WORD;
        end
    end

    wire is_rlc  = op_valid && (op_code == OP_ACC_ROTATE_LEFT_CIRCULAR);
    wire is_rra  = op_valid && (op_code == OP_ACC_ROTATE_RIGHT_VIA_CFLAG);
    wire is_rr   = op_valid && (op_code == OP_BYTE_ROTATE_RIGHT_VIA_CFLAG);
    wire is_word_rotate_right_circular = op_valid && (op_code == OP_WORD_ROTATE_RIGHT_CIRCULAR);
    wire is_sbc  = op_valid && (op_code == OP_BYTE_SUBTRACT_BORROW);

    acc_rlc_a: assert property (@(posedge clk) disable iff (reset)
        is_rlc |=> a_q == {$past(a_q[6:0]), $past(a_q[7])}
                   && flags_q[FLG_C] == $past(a_q[7]))
        else $error("left circular rotate wrong");
    acc_flags_a: assert property (@(posedge clk) disable iff (reset)
        (is_rlc || is_rra) |=> !flags_q[FLG_H] && !flags_q[FLG_N]
            && $stable(flags_q[FLG_S]) && $stable(flags_q[FLG_Z])
            && $stable(flags_q[FLG_PV]))
        else $error("accumulator rotate flags wrong");
    byte_ring_a: assert property (@(posedge clk) disable iff (reset)
        is_rr |=> result_q[7:0] == {$past(c_in), $past(src_byte[7:1])}
                  && flags_q[FLG_C] == $past(src_byte[0]))
        else $error("byte ring rotate wrong");
    acc_rra_a: assert property (@(posedge clk) disable iff (reset)
        is_rra |=> a_q == {$past(c_in), $past(a_q[7:1])})
        else $error("accumulator right rotate wrong");
    word_rot_a: assert property (@(posedge clk) disable iff (reset)
        is_word_rotate_right_circular |=> result_q == {$past(src_word[0]), $past(src_word[15:1])}
                    && flags_q[FLG_C] == $past(src_word[0]))
        else $error("word rotate wrong");
    rot_flags_a: assert property (@(posedge clk) disable iff (reset)
        is_word_rotate_right_circular |=> flags_q[FLG_S] == result_q[15] && flags_q[FLG_PV] == ~^result_q
            && flags_q[FLG_Z] == (result_q == RST_WORD) && !flags_q[FLG_N] && !flags_q[FLG_H])
        else $error("general rotate flags wrong");
    sbc_diff_a: assert property (@(posedge clk) disable iff (reset)
        is_sbc |=> a_q == 8'($past(a_q) - $past(src_byte) - $past({7'h00, c_in})))
        else $error("byte subtract result wrong");
    sbc_half_a: assert property (@(posedge clk) disable iff (reset)
        is_sbc |=> flags_q[FLG_N] && flags_q[FLG_H] == ({1'b0, $past(a_q[3:0])}
            < {1'b0, $past(src_byte[3:0])} + {4'h0, $past(c_in)}))
        else $error("byte half borrow wrong");
    // overflow: operands differ in sign, result takes the source sign
    sbc_ovf_a: assert property (@(posedge clk) disable iff (reset)
        is_sbc |=> flags_q[FLG_PV] == (($past(a_q[7]) != $past(src_byte[7]))
            && (a_q[7] == $past(src_byte[7]))))
        else $error("byte subtract overflow wrong");
    sbc_flags_a: assert property (@(posedge clk) disable iff (reset)
        is_sbc |=> flags_q[FLG_S] == a_q[7] && flags_q[FLG_Z] == (a_q == RST_BYTE)
            && flags_q[FLG_C] == ({1'b0, $past(a_q)}
            < {1'b0, $past(src_byte)} + {8'h00, $past(c_in)}))
        else $error("byte subtract sign, zero or carry wrong");
    word_subtract_borrow_res_a: assert property (@(posedge clk) disable iff (reset)
        op_word_sub |=> regs_q[SLOT_ACC_PAIR] == 16'($past(acc_word) - $past(src_word)
            - $past({15'h0000, c_in})) && result_q == regs_q[SLOT_ACC_PAIR] && flags_q[FLG_N])
        else $error("word subtract result wrong");
    word_subtract_borrow_half_a: assert property (@(posedge clk) disable iff (reset)
        op_word_sub |=> flags_q[FLG_H] == ({1'b0, $past(acc_word[11:0])}
            < {1'b0, $past(src_word[11:0])} + {12'h000, $past(c_in)}))
        else $error("word half borrow wrong");
    // software writes may land on a source slot, so those cycles are left out
    word_subtract_borrow_src_a: assert property (@(posedge clk) disable iff (reset)
        (op_word_sub || is_sbc) && wb_slot_ok && wb_slot != SLOT_ACC_PAIR && !reg_wr
        |=> regs_q[$past(wb_slot)] == $past(src_word))
        else $error("subtract changed its source");
    idx_byte_a: assert property (@(posedge clk) disable iff (reset)
        is_sbc && src_mode == SRC_INDEX && !index_sel |-> src_byte == (byte_sel
            ? regs_q[SLOT_FIRST_INDEX][7:0] : regs_q[SLOT_FIRST_INDEX][15:8]))
        else $error("index byte pick wrong");
    pair_pick_a: assert property (@(posedge clk) disable iff (reset)
        op_valid && src_mode == SRC_PAIR && pair_sel == PAIR_SECOND
        |-> src_word == regs_q[SLOT_SECOND_PAIR])
        else $error("pair field decode wrong");
    idx_pick_a: assert property (@(posedge clk) disable iff (reset)
        op_valid && src_mode == SRC_INDEX && index_sel
        |-> src_word == regs_q[SLOT_FIRST_INDEX + 3'h1])
        else $error("index register pick wrong");
    commit_a: assert property (@(posedge clk) disable iff (reset)
        op_valid |=> result_valid_q && result_q == $past(res_d) && flags_q == $past(f_d))
        else $error("result and flags not committed together");
    valid_pulse_a: assert property (@(posedge clk) disable iff (reset)
        !op_valid |=> !result_valid_q)
        else $error("result valid without operation");

    rlc_c: cover property (@(posedge clk) disable iff (reset) is_rlc);
    sbc_borrow_c: cover property (@(posedge clk) disable iff (reset)
        is_sbc && bdiff[8]);
    word_subtract_borrow_index_c: cover property (@(posedge clk) disable iff (reset)
        op_word_sub && src_mode == SRC_INDEX && index_sel);
    word_rotate_right_circular_pair_c: cover property (@(posedge clk) disable iff (reset)
        is_word_rotate_right_circular && src_mode == SRC_PAIR);
    sbc_ovf_c: cover property (@(posedge clk) disable iff (reset)
        is_sbc && (a_q[7] != src_byte[7]) && (bdiff[7] == src_byte[7]));
endmodule

// ===== sim/rsa_dec_model.sv
// rsa_dec_model: decoder stand-in that drives the alu operation port
// assumes bench requests arrive just after clk rising edges, at most one a cycle
`timescale 1ns/1ps
module rsa_dec_model
    import rsa_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // bench request
    input  wire logic        issue,
    input  wire rsa_op_t     req_op,
    input  wire rsa_src_t    req_src,
    input  wire logic [1:0]  req_pair,
    input  wire logic        req_index,
    input  wire logic        req_byte,
    input  wire logic [15:0] req_operand,
    // operation port toward the alu
    output logic             op_valid,
    output rsa_op_t          op_code,
    output rsa_src_t         src_mode,
    output logic [1:0]       pair_sel,
    output logic             index_sel,
    output logic             byte_sel,
    output logic [15:0]      operand_in
);
    // idle operand keeps toggling so a stale value never looks valid
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            op_valid   <= 1'b0;
            op_code    <= OP_ACC_ROTATE_LEFT_CIRCULAR;
            src_mode   <= SRC_EXTERNAL;
            pair_sel   <= 2'h0;
            index_sel  <= 1'b0;
            byte_sel   <= 1'b0;
            operand_in <= 16'h0000;
        end else if (issue) begin
            op_valid   <= 1'b1;
            op_code    <= req_op;
            src_mode   <= req_src;
            pair_sel   <= req_pair;
            index_sel  <= req_index;
            byte_sel   <= req_byte;
            operand_in <= req_operand;
        end else begin
            op_valid   <= 1'b0;
            operand_in <= ~operand_in;
        end
    end
endmodule

// ===== sim/tb_top.sv
// tb_top: self-checking bench for the rotate/subtract alu
// assumes the decoder stand-in adds one cycle between request and operation
`timescale 1ns/1ps
module tb_top
    import rsa_pkg::*;
;
    logic clk, reset, reg_wr, reg_rd, issue, rx, rb, rd_pend, op_valid, index_sel, byte_sel;
    logic [7:0] reg_addr, flags_q, m_acc, m_flg;
    logic [15:0] reg_wdata, rv, reg_rdata_q, result_q, operand_in, m_res, m_cnt;
    logic [15:0] m_slot[5];
    logic [1:0] rp, pair_sel;
    logic result_valid_q;
    rsa_op_t ro, op_code;
    rsa_src_t rs, src_mode;
    logic [23:0] oq[$];
    logic [15:0] rq[$];
    logic [31:0] lfsr;
    int error_cnt, total_checks;

    rsa_alu uut (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
        .op_valid, .op_code, .src_mode, .pair_sel, .index_sel, .byte_sel, .operand_in,
        .result_q, .result_valid_q, .flags_q);
    rsa_dec_model dec (.clk, .reset, .issue, .req_op(ro), .req_src(rs), .req_pair(rp),
        .req_index(rx), .req_byte(rb), .req_operand(rv), .op_valid, .op_code, .src_mode,
        .pair_sel, .index_sel, .byte_sel, .operand_in);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic fail(input string msg);
        error_cnt++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask

    task automatic cmp_op(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) fail("operation result or flags");
    endtask

    task automatic cmp_rd(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) fail("register read data");
    endtask

    task automatic conclude();
        if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // every strobe assigned once per call, so calls may follow with no gap
    task automatic step(input logic w, r, i, input logic [7:0] a, input logic [15:0] d);
        reg_wr <= w; reg_rd <= r; issue <= i; reg_addr <= a; reg_wdata <= d;
        @(posedge clk);
    endtask

    function automatic logic [15:0] rd_exp(input logic [7:0] a);
        if (a == OFS_ACC) return {8'h00, m_acc};
        if (a == OFS_FLAGS) return {8'h00, m_flg};
        if (a >= OFS_SLOT0 && a < OFS_RESULT && a[1:0] == 2'h0) return m_slot[(a - OFS_SLOT0) >> 2];
        if (a == OFS_RESULT) return m_res;
        if (a == OFS_COUNT) return m_cnt;
        return 16'h0000;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        if (a == OFS_ACC) m_acc = d[7:0];
        else if (a == OFS_FLAGS) m_flg = d[7:0];
        else if (a >= OFS_SLOT0 && a < OFS_RESULT && a[1:0] == 2'h0) m_slot[(a - OFS_SLOT0) >> 2] = d;
        step(1'b1, 1'b0, 1'b0, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        rq.push_back(rd_exp(a));
        step(1'b0, 1'b1, 1'b0, a, 16'h0000);
    endtask

    task automatic op(input rsa_op_t o, input rsa_src_t s, input logic [1:0] p,
                      input logic x, b, input logic [15:0] v);
        logic [16:0] d;
        logic [15:0] w, r, bw;
        logic [7:0] f, y;
        logic [2:0] k;
        logic c;
        k = (s == SRC_PAIR) ? ((p == PAIR_FIRST) ? 3'h0 : (p == PAIR_SECOND) ? 3'h1 : 3'h2)
                            : 3'h3 + {2'h0, x};
        w = (s == SRC_EXTERNAL) ? v : m_slot[k];
        bw = (s == SRC_INDEX) ? m_slot[3'h3 + {2'h0, x}] : v;
        y = (s == SRC_INDEX && !b) ? bw[15:8] : bw[7:0];
        f = m_flg; c = f[FLG_C]; r = 16'h0000;
        case (o)
            OP_ACC_ROTATE_LEFT_CIRCULAR: begin r[7:0] = {m_acc[6:0], m_acc[7]}; c = m_acc[7]; end
            OP_ACC_ROTATE_RIGHT_VIA_CFLAG: begin r[7:0] = {c, m_acc[7:1]}; c = m_acc[0]; end
            OP_BYTE_ROTATE_RIGHT_VIA_CFLAG: begin r[7:0] = {c, y[7:1]}; c = y[0]; end
            OP_WORD_ROTATE_RIGHT_CIRCULAR: begin r = {w[0], w[15:1]}; c = w[0]; end
            OP_BYTE_SUBTRACT_BORROW: begin
                d = {9'h000, m_acc} - {9'h000, y} - {16'h0000, c};
                f[FLG_H] = ({1'b0, m_acc[3:0]} < {1'b0, y[3:0]} + {4'h0, c});
                f[FLG_PV] = (m_acc[7] != y[7]) && (d[7] == y[7]);
                r[7:0] = d[7:0]; c = d[8]; m_acc = d[7:0];
            end
            OP_WORD_SUBTRACT_BORROW: begin
                d = {1'b0, m_slot[2]} - {1'b0, w} - {16'h0000, c};
                f[FLG_H] = ({1'b0, m_slot[2][11:0]} < {1'b0, w[11:0]} + {12'h000, c});
                f[FLG_PV] = (m_slot[2][15] != w[15]) && (d[15] == w[15]);
                r = d[15:0]; c = d[16]; m_slot[2] = r;
            end
            default: ;
        endcase
        f[FLG_C] = c;
        if (o <= OP_ACC_ROTATE_RIGHT_VIA_CFLAG) m_acc = r[7:0];
        if (o >= OP_BYTE_ROTATE_RIGHT_VIA_CFLAG) begin
            f[FLG_S] = (o == OP_BYTE_ROTATE_RIGHT_VIA_CFLAG || o == OP_BYTE_SUBTRACT_BORROW)
                       ? r[7] : r[15];
            f[FLG_Z] = (r == 16'h0000);
            if (o <= OP_WORD_ROTATE_RIGHT_CIRCULAR) f[FLG_PV] = ~^r;
        end
        f[FLG_H] = (o >= OP_BYTE_SUBTRACT_BORROW) ? f[FLG_H] : 1'b0;
        f[FLG_N] = (o >= OP_BYTE_SUBTRACT_BORROW);
        if (o == OP_WORD_ROTATE_RIGHT_CIRCULAR && s != SRC_EXTERNAL) m_slot[k] = r;
        m_flg = f; m_res = r; m_cnt++;
        oq.push_back({r, f});
        ro <= o; rs <= s; rp <= p; rx <= x; rb <= b; rv <= v;
        step(1'b0, 1'b0, 1'b1, 8'h00, 16'h0000);
    endtask

    always @(posedge clk) rd_pend <= reg_rd;

    // results are registered, so look at them mid-cycle
    always @(negedge clk) begin
        if (result_valid_q === 1'b1) begin
            if (oq.size() == 0) fail("unexpected result strobe");
            else cmp_op({result_q, flags_q}, oq.pop_front());
        end
        if (rd_pend === 1'b1) begin
            if (rq.size() == 0) fail("unexpected read data");
            else cmp_rd(reg_rdata_q, rq.pop_front());
        end
    end

    initial begin
        reset = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; issue = 1'b0; rd_pend = 1'b0;
        reg_addr = 8'h00; reg_wdata = 16'h0000; ro = OP_ACC_ROTATE_LEFT_CIRCULAR;
        rs = SRC_EXTERNAL; rp = 2'h0; rx = 1'b0; rb = 1'b0; rv = 16'h0000;
        m_acc = RST_BYTE; m_flg = RST_BYTE; m_res = RST_WORD; m_cnt = RST_WORD;
        for (int i = 0; i < NUM_SLOTS; i++) m_slot[i] = RST_WORD;
        lfsr = 32'hF9D87AD2; error_cnt = 0; total_checks = 0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        for (int a = 0; a <= 36; a += 4) rd(a[7:0]);
        op(OP_BYTE_SUBTRACT_BORROW, SRC_EXTERNAL, 2'h0, 1'b0, 1'b0, 16'h0001);
        step(1'b0, 1'b0, 1'b0, 8'h00, 16'h0000);
        step(1'b0, 1'b0, 1'b0, 8'h00, 16'h0000);
        wr(OFS_ACC, 16'h0081);
        wr(OFS_FLAGS, 16'h0028);
        op(OP_ACC_ROTATE_LEFT_CIRCULAR, SRC_EXTERNAL, 2'h0, 1'b0, 1'b0, 16'h0000);
        op(OP_ACC_ROTATE_RIGHT_VIA_CFLAG, SRC_EXTERNAL, 2'h0, 1'b0, 1'b0, 16'h0000);
        op(OP_BYTE_ROTATE_RIGHT_VIA_CFLAG, SRC_EXTERNAL, 2'h0, 1'b0, 1'b0, 16'h0002);
        op(OP_WORD_ROTATE_RIGHT_CIRCULAR, SRC_EXTERNAL, 2'h0, 1'b0, 1'b0, 16'h0001);
        op(OP_BYTE_SUBTRACT_BORROW, SRC_EXTERNAL, 2'h0, 1'b0, 1'b0, 16'h007F);
        step(1'b0, 1'b0, 1'b0, 8'h00, 16'h0000);
        step(1'b0, 1'b0, 1'b0, 8'h00, 16'h0000);
        wr(8'h08, 16'h0001); wr(8'h0C, 16'h8000); wr(8'h10, 16'h1000);
        wr(8'h14, 16'hA55A); wr(8'h18, 16'h3C01);
        op(OP_WORD_SUBTRACT_BORROW, SRC_PAIR, PAIR_FIRST, 1'b0, 1'b0, 16'h0000);
        for (int i = 0; i < 4; i++) op(OP_WORD_ROTATE_RIGHT_CIRCULAR, SRC_PAIR, i[1:0], 1'b0, 1'b0, 16'h0000);
        for (int i = 0; i < 4; i++) op(OP_BYTE_SUBTRACT_BORROW, SRC_INDEX, 2'h0, i[1], i[0], 16'h0000);
        op(OP_WORD_ROTATE_RIGHT_CIRCULAR, SRC_INDEX, 2'h0, 1'b1, 1'b0, 16'h0000);
        step(1'b0, 1'b0, 1'b0, 8'h00, 16'h0000);
        step(1'b0, 1'b0, 1'b0, 8'h00, 16'h0000);
        wr(OFS_RESULT, 16'hFFFF);
        wr(OFS_COUNT, 16'hFFFF);
        for (int a = 0; a <= 36; a += 4) rd(a[7:0]);
        for (int i = 0; i < 200; i++) begin
            lfsr = nxt(lfsr);
            op(rsa_op_t'(lfsr[2:0] % 3'h6), rsa_src_t'(lfsr[4:3] % 2'h3), lfsr[6:5], lfsr[7], lfsr[8], lfsr[31:16]);
        end
        for (int k = 0; k < 10 && (oq.size() != 0 || rq.size() != 0 || k < 2); k++)
            step(1'b0, 1'b0, 1'b0, 8'h00, 16'h0000);
        for (int a = 0; a <= 36; a += 4) rd(a[7:0]);
        for (int k = 0; k < 10 && rq.size() != 0; k++) step(1'b0, 1'b0, 1'b0, 8'h00, 16'h0000);
        if (oq.size() != 0 || rq.size() != 0) fail("expected result never appeared");
        conclude();
    end
endmodule
